// ### verilog/lpm_top.sv
// Purpose: low-power state control, post-reset self configuration and indicator pins
// Assumes: APB inputs and event inputs synchronous to CLK; POWERDOWN_N is asynchronous
// Notes: CORE_RESET_N holds the rest of the controller in reset in every low-power state
//
// How it works
// - pin low with lowpower and cable-watch bits set enters link-watch standby
// - standby ignores all bus accesses; only the link receiver stays alive
// - standby drives activity led low while link activity is seen
// - entering standby resets everything except the self-control register
// - pin going high leaves standby through full reset and initialisation
// - pin low, lowpower set, cable-watch clear enters hardware suspend
// - hardware suspend ignores bus and network, link detection off
// - outside party raises pin to leave suspend; device resets and reinitialises
// - software suspend keeps only I/O base and self-control registers
// - any write during software suspend wakes, discards data, resets, reinitialises
// - hardware reset leaves any low-power state at once
// - hardware states outrank software suspend
// - every exit resets, calibrates, then checks and loads EEPROM
// - on completion set init_done and clear serial_if_busy
// - activity led low on tx, rx or collision, held 6 ms after last
// - pin owned by device shows link pulses on link led
// - pin owned by host follows inverted host level bit
`timescale 1ns/1ps
`default_nettype none

module lpm_top
   import lpm_pkg::*;
#(
   parameter logic [`LPM_CNT_W-1:0] CAL_CYC = `LPM_CNT_W'(`LPM_CAL_CYC),
   parameter logic [`LPM_CNT_W-1:0] LED_CYC = `LPM_CNT_W'(`LPM_LED_CYC),
   parameter logic [`LPM_CNT_W-1:0] RST_CYC = `LPM_CNT_W'(`LPM_RST_CYC)
) (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [`LPM_ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic POWERDOWN_N,
   input wire logic LINK_PULSE_OK,
   input wire logic LINK_ACTIVITY,
   input wire logic TX_EVENT,
   input wire logic RX_EVENT,
   input wire logic COLLISION,
   input wire logic EE_LOAD_DONE,
   output logic ACT_LED_N,
   output logic LINK_LED_N,
   output logic CORE_RESET_N,
   output logic CAL_RUN,
   output logic EE_LOAD_REQ
);

   lpm_regs_s r_q;
   lpm_regs_s r_d;

   localparam lpm_regs_s REGS_RST = '{
      st: ST_RST,
      cnt: RST_CYC - `LPM_CNT_W'(1),
      led_cnt: '0,
      pd_meta: 1'b1,
      pd_sync: 1'b1,
      self_control_reg: `LPM_SELF_CONTROL_REG_RST,
      iobase: `LPM_IOBASE_RST,
      init_done: 1'b0,
      si_busy: 1'b1,
      prdata: '0,
      pready: 1'b0,
      pslverr: 1'b0,
      act_led_n: 1'b1,
      link_led_n: 1'b1,
      core_rst_n: 1'b0,
      cal_run: 1'b0,
      ee_req: 1'b0
   };

   logic sleep;
   logic hw_low;
   logic setup;
   logic wr_done;
   logic blocked;
   logic in_hw;
   logic activity;

   always_comb begin
      r_d = r_q;

      // first stage feeds only the second
      r_d.pd_meta = POWERDOWN_N;
      r_d.pd_sync = r_q.pd_meta;
      sleep = ~r_q.pd_sync;
      hw_low = sleep & r_q.self_control_reg[`LPM_BIT_HWLPEN];

      in_hw = (r_q.st == ST_STBY) || (r_q.st == ST_HWS);
      blocked = in_hw || (r_q.st == ST_SWS);
      setup = PSEL & ~PENABLE;
      wr_done = PSEL & PENABLE & r_q.pready & PWRITE;

      // one wait-free access phase: answer is registered from the setup cycle
      r_d.pready = setup;
      r_d.pslverr = 1'b0;
      r_d.prdata = '0;
      if (setup && !blocked) begin
         case (PADDR)
            `LPM_OFS_IOBASE: r_d.prdata = {16'h0000, r_q.iobase};
            `LPM_OFS_SELF_CONTROL_REG: r_d.prdata = {16'h0000, r_q.self_control_reg};
            `LPM_OFS_SELFST: begin
               r_d.prdata[`LPM_BIT_INIT_DONE] = r_q.init_done;
               r_d.prdata[`LPM_BIT_SERIAL_IF_BUSY] = r_q.si_busy;
            end
            default: r_d.pslverr = 1'b1;
         endcase
      end

      if (wr_done && !blocked) begin
         case (PADDR)
            `LPM_OFS_IOBASE: r_d.iobase = PWDATA[15:0];
            `LPM_OFS_SELF_CONTROL_REG: r_d.self_control_reg = PWDATA[15:0] & `LPM_SELF_CONTROL_REG_MASK;
            default: r_d.iobase = r_q.iobase;
         endcase
      end

      case (r_q.st)
         ST_RST: begin
            r_d.core_rst_n = 1'b0;
            r_d.si_busy = 1'b1;
            if (r_q.cnt == '0) begin
               r_d.st = ST_CAL;
               r_d.core_rst_n = 1'b1;
               r_d.cal_run = 1'b1;
               r_d.cnt = CAL_CYC - `LPM_CNT_W'(1);
            end else begin
               r_d.cnt = r_q.cnt - `LPM_CNT_W'(1);
            end
         end
         ST_CAL: begin
            if (r_q.cnt == '0) begin
               r_d.st = ST_EE;
               r_d.cal_run = 1'b0;
               r_d.ee_req = 1'b1;
            end else begin
               r_d.cnt = r_q.cnt - `LPM_CNT_W'(1);
            end
         end
         ST_EE: begin
            if (EE_LOAD_DONE) begin
               r_d.st = ST_RUN;
               r_d.ee_req = 1'b0;
               r_d.init_done = 1'b1;
               r_d.si_busy = 1'b0;
            end
         end
         ST_RUN: begin
            if (r_q.self_control_reg[`LPM_BIT_SWDOZE]) begin
               r_d.st = ST_SWS;
               r_d.core_rst_n = 1'b0;
               r_d.init_done = 1'b0;
            end
         end
         ST_STBY, ST_HWS: begin
            if (!sleep) begin
               // leaving hardware sleep always passes through reset
               r_d.st = ST_RST;
               r_d.cnt = RST_CYC - `LPM_CNT_W'(1);
               r_d.self_control_reg[`LPM_BIT_SWDOZE] = 1'b0;
            end
         end
         ST_SWS: begin
            if (wr_done) begin
               // the waking write is dropped by the blocked decode above
               r_d.st = ST_RST;
               r_d.cnt = RST_CYC - `LPM_CNT_W'(1);
               r_d.self_control_reg[`LPM_BIT_SWDOZE] = 1'b0;
            end
         end
         default: begin
            r_d.st = ST_RST;
            r_d.cnt = RST_CYC - `LPM_CNT_W'(1);
         end
      endcase

      // hardware sleep overrides init, run and software suspend
      if (!in_hw && hw_low) begin
         if (r_q.self_control_reg[`LPM_BIT_CWATCH]) begin
            r_d.st = ST_STBY;
         end else begin
            r_d.st = ST_HWS;
         end
         r_d.core_rst_n = 1'b0;
         r_d.iobase = `LPM_IOBASE_RST;
         r_d.init_done = 1'b0;
         r_d.si_busy = 1'b0;
         r_d.cal_run = 1'b0;
         r_d.ee_req = 1'b0;
         r_d.prdata = '0;
         r_d.pslverr = 1'b0;
      end

      activity = TX_EVENT | RX_EVENT | COLLISION;
      case (r_d.st)
         ST_STBY: begin
            r_d.led_cnt = '0;
            r_d.act_led_n = ~LINK_ACTIVITY;
            r_d.link_led_n = 1'b1;
         end
         ST_HWS, ST_SWS: begin
            r_d.led_cnt = '0;
            r_d.act_led_n = 1'b1;
            r_d.link_led_n = 1'b1;
         end
         default: begin
            // retrigger on every event so the low time stretches from the last one
            if (activity) begin
               r_d.led_cnt = LED_CYC;
            end else if (r_q.led_cnt != '0) begin
               r_d.led_cnt = r_q.led_cnt - `LPM_CNT_W'(1);
            end
            r_d.act_led_n = (r_d.led_cnt == '0);
            if (r_q.self_control_reg[`LPM_BIT_P0OWN]) begin
               r_d.link_led_n = ~r_q.self_control_reg[`LPM_BIT_P0LVL];
            end else begin
               r_d.link_led_n = ~LINK_PULSE_OK;
            end
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         r_q <= REGS_RST;
      end else begin
         r_q <= r_d;
      end
   end

   assign PRDATA = r_q.prdata;
   assign PREADY = r_q.pready;
   assign PSLVERR = r_q.pslverr;
   assign ACT_LED_N = r_q.act_led_n;
   assign LINK_LED_N = r_q.link_led_n;
   assign CORE_RESET_N = r_q.core_rst_n;
   assign CAL_RUN = r_q.cal_run;
   assign EE_LOAD_REQ = r_q.ee_req;

endmodule

`default_nettype wire

// ### verilog/lpm_consts.svh
// Purpose: constants for the low-power mode and indicator pin block
// Assumes: 25 MHz device clock, 32-bit APB register bus
// Notes: times in microseconds, calibration and LED cycle counts derived from the clock rate
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH

`define LPM_ADDR_W 12
`define LPM_OFS_IOBASE 12'h020
`define LPM_OFS_SELF_CONTROL_REG 12'h03C
`define LPM_OFS_SELFST 12'h040

`define LPM_BIT_SWDOZE 8
`define LPM_BIT_HWLPEN 9
`define LPM_BIT_CWATCH 10
`define LPM_BIT_P0OWN 12
`define LPM_BIT_P0LVL 14
`define LPM_SELF_CONTROL_REG_MASK 16'h5700
`define LPM_SELF_CONTROL_REG_RST 16'h0000
`define LPM_IOBASE_RST 16'h0300

`define LPM_BIT_INIT_DONE 7
`define LPM_BIT_SERIAL_IF_BUSY 8

`define LPM_CLK_MHZ 25
`define LPM_CAL_TIME_US 10000
`define LPM_LED_HOLD_US 6000
`define LPM_CAL_CYC (`LPM_CAL_TIME_US * `LPM_CLK_MHZ)
`define LPM_LED_CYC (`LPM_LED_HOLD_US * `LPM_CLK_MHZ)
`define LPM_RST_CYC 4
`define LPM_CNT_W 20

`endif

// ### verilog/lpm_pkg.sv
// Purpose: types for the low-power mode and indicator pin block
// Assumes: constants come from lpm_consts.svh
// Notes: the whole block state is one packed struct
`default_nettype none
`include "lpm_consts.svh"

package lpm_pkg;

   typedef enum logic [6:0] {
      ST_RST  = 7'b000_0001,
      ST_CAL  = 7'b000_0010,
      ST_EE   = 7'b000_0100,
      ST_RUN  = 7'b000_1000,
      ST_STBY = 7'b001_0000,
      ST_HWS  = 7'b010_0000,
      ST_SWS  = 7'b100_0000
   } lpm_state_e;

   typedef struct packed {
      lpm_state_e st;
      logic [`LPM_CNT_W-1:0] cnt;
      logic [`LPM_CNT_W-1:0] led_cnt;
      logic pd_meta;
      logic pd_sync;
      logic [15:0] self_control_reg;
      logic [15:0] iobase;
      logic init_done;
      logic si_busy;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic act_led_n;
      logic link_led_n;
      logic core_rst_n;
      logic cal_run;
      logic ee_req;
   } lpm_regs_s;

endpackage

`default_nettype wire

// ### verification/lpm_ee_model.sv
// Purpose: stand-in for the configuration loader beside the low-power block
// Assumes: SLOW picks a long or a short load time
// Notes: done is registered and drops one clock after the request goes away
`timescale 1ns/1ps
`default_nettype none
module lpm_ee_model (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic EE_LOAD_REQ,
   input wire logic SLOW,
   output logic EE_LOAD_DONE
);
   logic [3:0] wait_q;
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         wait_q <= 4'h0;
         EE_LOAD_DONE <= 1'b0;
      end else begin
         wait_q <= EE_LOAD_REQ ? wait_q + 4'h1 : 4'h0;
         EE_LOAD_DONE <= EE_LOAD_REQ && (wait_q >= (SLOW ? 4'h9 : 4'h1));
      end
   end
endmodule
`default_nettype wire

// ### verification/lpm_props.sv
// Purpose: port checks for lpm_top
// Assumes: bench runs with LED_CYC and CAL_CYC of at least 8
// Notes: bound below the module
`timescale 1ns/1ps
`default_nettype none
module lpm_props (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic PREADY,
   input wire logic POWERDOWN_N,
   input wire logic TX_EVENT,
   input wire logic RX_EVENT,
   input wire logic COLLISION,
   input wire logic EE_LOAD_DONE,
   input wire logic ACT_LED_N,
   input wire logic CORE_RESET_N,
   input wire logic CAL_RUN,
   input wire logic EE_LOAD_REQ
);
   logic ev;
   assign ev = TX_EVENT | RX_EVENT | COLLISION;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   a_reset_quiet: assert property (disable iff (1'b0)
      !RESET_N |-> !CORE_RESET_N && !PREADY && ACT_LED_N && !CAL_RUN) else $error("busy in reset");
   a_led_on: assert property (ev && CORE_RESET_N |=> !ACT_LED_N || !CORE_RESET_N)
      else $error("activity led missed event");
   a_led_hold: assert property (ev && CORE_RESET_N |=> (!ACT_LED_N || !CORE_RESET_N)[*8])
      else $error("activity led released early");
   a_core_to_cal: assert property ($rose(CORE_RESET_N) |-> CAL_RUN)
      else $error("no calibration after internal reset");
   a_cal_length: assert property ($rose(CAL_RUN) |-> (CAL_RUN || !CORE_RESET_N)[*8])
      else $error("calibration cut short");
   a_cal_then_ee: assert property ($fell(CAL_RUN) && CORE_RESET_N |-> EE_LOAD_REQ)
      else $error("no load after calibration");
   a_ee_wait_done: assert property ($fell(EE_LOAD_REQ) && CORE_RESET_N |-> $past(EE_LOAD_DONE))
      else $error("load ended without done");
   a_wake_init: assert property ($rose(POWERDOWN_N) && !CORE_RESET_N |-> ##[1:12] CAL_RUN)
      else $error("no wake after pin high");
   cover property ($fell(EE_LOAD_REQ));
   cover property (!ACT_LED_N && !CORE_RESET_N);
   cover property ($rose(POWERDOWN_N) && !CORE_RESET_N);
endmodule
bind lpm_top lpm_props u_props (.CLK(CLK), .RESET_N(RESET_N), .PREADY(PREADY),
   .POWERDOWN_N(POWERDOWN_N), .TX_EVENT(TX_EVENT), .RX_EVENT(RX_EVENT),
   .COLLISION(COLLISION), .EE_LOAD_DONE(EE_LOAD_DONE), .ACT_LED_N(ACT_LED_N),
   .CORE_RESET_N(CORE_RESET_N), .CAL_RUN(CAL_RUN), .EE_LOAD_REQ(EE_LOAD_REQ));
`default_nettype wire

// ### verification/testbench.sv
// Purpose: self-checking bench for lpm_top
// Assumes: short counts, CAL_CYC 20 and LED_CYC 10
// Notes: random data from an xorshift seeded with 91145
`timescale 1ns/1ps
`default_nettype none
`include "lpm_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
   localparam int LED = 10;
   logic clk = 0, rst_n = 1, psel = 0, pen = 0, pwr = 0, pdn_n = 1, lpok = 0, lact = 0;
   logic tx = 0, rx = 0, col = 0, slow = 0, ee_done, pready, pslverr, act_n, link_n;
   logic core_n, cal, ee_req, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, v;
   logic [31:0] rs = 32'h0001_6409;
   int n_errors = 0, samples_checked = 0, cyc = 0, i;
   lpm_top #(.CAL_CYC(20'h0_0014), .LED_CYC(20'h0_000A)) i_lpm_top (.CLK(clk), .RESET_N(rst_n),
      .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .POWERDOWN_N(pdn_n), .LINK_PULSE_OK(lpok),
      .LINK_ACTIVITY(lact), .TX_EVENT(tx), .RX_EVENT(rx), .COLLISION(col),
      .EE_LOAD_DONE(ee_done), .ACT_LED_N(act_n), .LINK_LED_N(link_n), .CORE_RESET_N(core_n),
      .CAL_RUN(cal), .EE_LOAD_REQ(ee_req));
   lpm_ee_model i_lpm_ee_model (.CLK(clk), .RESET_N(rst_n), .EE_LOAD_REQ(ee_req),
      .SLOW(slow), .EE_LOAD_DONE(ee_done));
   always #20 clk = ~clk;
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   function automatic logic exp_link(input logic own, input logic lvl, input logic lp);
      return own ? ~lvl : ~lp;
   endfunction
   task automatic summarize();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         summarize();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic apb(input int w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= 1'(w);
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // host keeps off the registers until loading is over
   task automatic wait_init();
      logic [31:0] s;
      s = rnd();
      slow <= s[0];
      tick(4);
      while (core_n !== 1'b1 || cal !== 1'b0 || ee_req !== 1'b0) @(posedge clk);
   endtask
   initial begin
      // a real falling edge at time zero, so no flop is still unknown at the first clock
      rst_n <= 1'b0;
      tick(6);
      rst_n <= 1'b1;
      apb(0, `LPM_OFS_SELFST, 0);
      `CHK(rd, 32'h0000_0100)
      wait_init();
      apb(0, `LPM_OFS_SELFST, 0);
      `CHK(rd, 32'h0000_0080)
      apb(0, 12'h100, 0);
      `CHK(err, 1'b1)
      for (i = 0; i < 4; i++) begin
         v = rnd();
         lpok <= v[0];
         apb(1, `LPM_OFS_SELF_CONTROL_REG, {17'h0_0000, i[1], 1'b0, i[0], 12'h000});
         tick(2);
         `CHK(link_n, exp_link(i[0], i[1], v[0]))
      end
      for (i = 0; i < 3; i++) begin
         {col, rx, tx} <= 3'b001 << i;
         @(posedge clk);
         {col, rx, tx} <= 3'b000;
         tick(2);
         `CHK(act_n, 1'b0)
         tick(LED - 2);
         `CHK(act_n, 1'b0)
         tick(1);
         `CHK(act_n, 1'b1)
      end
      v = rnd();
      apb(1, `LPM_OFS_IOBASE, {16'h0000, v[15:0]});
      apb(1, `LPM_OFS_SELF_CONTROL_REG, 32'h0000_0100);
      apb(0, `LPM_OFS_SELF_CONTROL_REG, 0);
      `CHK(rd, 32'h0000_0000)
      `CHK(core_n, 1'b0)
      apb(1, `LPM_OFS_IOBASE, ~v);
      wait_init();
      apb(0, `LPM_OFS_IOBASE, 0);
      `CHK(rd, {16'h0000, v[15:0]})
      apb(1, `LPM_OFS_SELF_CONTROL_REG, 32'h0000_0600);
      pdn_n <= 1'b0;
      lact <= 1'b1;
      tick(6);
      `CHK(act_n, 1'b0)
      apb(0, `LPM_OFS_SELFST, 0);
      `CHK(rd, 32'h0000_0000)
      apb(0, 12'h100, 0);
      `CHK({err, rd}, 33'h0_0000_0000)
      lact <= 1'b0;
      tick(2);
      `CHK(act_n, 1'b1)
      lact <= 1'b1;
      pdn_n <= 1'b1;
      wait_init();
      apb(0, `LPM_OFS_SELF_CONTROL_REG, 0);
      `CHK(rd, 32'h0000_0600)
      apb(0, `LPM_OFS_IOBASE, 0);
      `CHK(rd, 32'h0000_0300)
      apb(1, `LPM_OFS_SELF_CONTROL_REG, 32'h0000_0200);
      pdn_n <= 1'b0;
      tick(6);
      `CHK({core_n, act_n}, 2'b01)
      rst_n <= 1'b0;
      tick(2);
      rst_n <= 1'b1;
      wait_init();
      `CHK(core_n, 1'b1)
      apb(0, `LPM_OFS_SELF_CONTROL_REG, 0);
      `CHK(rd, 32'h0000_0000)
      apb(1, `LPM_OFS_SELF_CONTROL_REG, 32'h0000_0300);
      tick(4);
      apb(1, `LPM_OFS_IOBASE, 0);
      // long enough that a software wake would already be calibrating
      tick(8);
      `CHK(core_n, 1'b0)
      pdn_n <= 1'b1;
      lact <= 1'b0;
      wait_init();
      summarize();
   end
endmodule
`default_nettype wire
